// ---- dpm_pkg.sv ----
// package: constants and types for the dual-port memory port controller
package dpm_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    // strobe timing at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS      = 5;   // address/data ahead of strobe
    localparam int PULSE_NS      = 40;  // write or read strobe width
    localparam int FLAG_PULSE_NS = 15;  // flag_update_pulse minimum
    localparam int RECOVER_NS    = 15;  // gap before next access
    localparam int SETUP_CYC   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC   = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLAG_CYC    =
        (FLAG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC =
        (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [DATA_W-1:0] FLAG_TAKE = 8'h00;
    localparam logic [DATA_W-1:0] FLAG_FREE = 8'hFF;

    // user command codes
    typedef enum logic [2:0] {
        DPM_CMD_READ  = 3'h0,
        DPM_CMD_WRITE = 3'h1,
        DPM_CMD_TAKE  = 3'h2,  // request flag, report grant
        DPM_CMD_FREE  = 3'h3,  // release flag
        DPM_CMD_FLAG  = 3'h4   // read flag state only
    } dpm_cmd_t;

    typedef struct packed {
        dpm_cmd_t            cmd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } dpm_req_t;

    // pins toward one device port, all active-low strobes except rw
    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic                sel_n;
        logic                rw;
        logic                oe_n;
        logic                flag_select_n;
    } dpm_pins_t;

    localparam dpm_pins_t PINS_IDLE = '{addr: '0, sel_n: 1'b1, rw: 1'b1,
                                        oe_n: 1'b1, flag_select_n: 1'b1};
endpackage

// ---- dpm_host.sv ----
// host-side controller that drives one port of the dual-port memory
`timescale 1ns/1ps
`default_nettype none
module dpm_host
    import dpm_pkg::*;
(
    input  wire logic              ref_clk_in,   // 100 MHz clock
    input  wire logic              rst_in,       // async reset, active high
    input  wire dpm_req_t          req_in,       // command, address, data
    input  wire logic              req_valid_in, // request offered
    output logic                   req_ready_out, // idle, request taken
    output logic                   done_out,     // one-cycle completion
    output logic [DATA_W-1:0]      rdata_out,    // read data or flag value
    output logic                   granted_out,  // take command won flag
    output dpm_pins_t              pins_out,     // strobes and address
    output logic [DATA_W-1:0]      data_out,     // data pin output value
    output logic                   data_oe_out,  // high while host drives
    input  wire logic [DATA_W-1:0] data_in       // data pin level
);
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_PULSE = 5'b00100,
        ST_RECOV = 5'b01000,
        ST_CHECK = 5'b10000
    } dpm_state_t;

    dpm_state_t        state_q, state_d;
    dpm_req_t          req_q, req_d;
    dpm_pins_t         pins_q, pins_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic              oe_q, oe_d, done_q, done_d, grant_q, grant_d;
    logic [DATA_W-1:0] din_s1_q, din_s2_q;

    // data pins come from another timing domain: two flops first
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            din_s1_q <= '0;
            din_s2_q <= '0;
        end else begin
            din_s1_q <= data_in;
            din_s2_q <= din_s1_q;
        end
    end

    // sequencer next values
    always_comb begin
        state_d = state_q;
        req_d   = req_q;
        pins_d  = pins_q;
        cnt_d   = cnt_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        oe_d    = oe_q;
        done_d  = 1'b0;
        grant_d = grant_q;
        case (state_q)
            ST_IDLE: begin
                // all strobes parked high: rw high while address moves
                pins_d = PINS_IDLE;
                pins_d.addr = pins_q.addr;
                if (req_valid_in) begin
                    req_d = req_in;
                    // address set while every strobe is released
                    pins_d.addr = req_in.addr;
                    cnt_d = CNT_W'(SETUP_CYC);
                    state_d = ST_SETUP;
                    case (req_in.cmd)
                        DPM_CMD_WRITE: wdata_d = req_in.data;
                        // a zero write requests the flag
                        DPM_CMD_TAKE: wdata_d = FLAG_TAKE;
                        DPM_CMD_FREE: wdata_d = FLAG_FREE;
                        default: wdata_d = wdata_q;
                    endcase
                end
            end
            ST_SETUP: begin
                if (cnt_q > CNT_W'(1)) begin
                    cnt_d = cnt_q - CNT_W'(1);
                end else begin
                    // select and rw fall together, so device outputs
                    // stay off and the host may drive at once
                    case (req_q.cmd)
                        DPM_CMD_READ: begin
                            pins_d.sel_n = 1'b0;
                            pins_d.oe_n  = 1'b0;
                        end
                        DPM_CMD_WRITE: begin
                            pins_d.sel_n = 1'b0;
                            pins_d.rw    = 1'b0;
                            oe_d         = 1'b1;
                        end
                        DPM_CMD_FLAG: begin
                            // explicit strobe refreshes flag value
                            pins_d.flag_select_n = 1'b0;
                            pins_d.oe_n          = 1'b0;
                        end
                        default: begin
                            // sel_n stays high: flag write only
                            pins_d.flag_select_n = 1'b0;
                            pins_d.rw            = 1'b0;
                            oe_d                 = 1'b1;
                        end
                    endcase
                    // every read, flag reads too, gets the long pulse:
                    // the two sync flops must settle before release
                    cnt_d = (req_q.cmd == DPM_CMD_TAKE ||
                             req_q.cmd == DPM_CMD_FREE) ?
                            CNT_W'(FLAG_CYC) : CNT_W'(PULSE_CYC);
                    state_d = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (cnt_q > CNT_W'(1)) begin
                    cnt_d = cnt_q - CNT_W'(1);
                end else begin
                    // sample through sync (pins held steady two cycles)
                    rdata_d = din_s2_q;
                    // all strobes rise together; data stays one cycle
                    pins_d = PINS_IDLE;
                    pins_d.addr = pins_q.addr;
                    cnt_d = CNT_W'(RECOVER_CYC);
                    state_d = ST_RECOV;
                end
            end
            ST_RECOV: begin
                oe_d = 1'b0;                            // hold past release
                if (cnt_q > CNT_W'(1)) begin
                    cnt_d = cnt_q - CNT_W'(1);
                end else if (req_q.cmd == DPM_CMD_TAKE) begin
                    // read back the flag, sel_n still high
                    req_d.cmd = DPM_CMD_FLAG;
                    cnt_d = CNT_W'(SETUP_CYC);
                    state_d = ST_CHECK;
                end else begin
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_CHECK: begin
                // flag read-back follows the normal setup path
                state_d = ST_SETUP;
            end
            default: begin
                state_d = ST_IDLE;
                pins_d  = PINS_IDLE;
                oe_d    = 1'b0;
            end
        endcase
        // every completed flag read, take read-back or standalone, reports grant on zero;
        // no array arbitration, so software guards shared cells by it
        if (state_q == ST_RECOV && cnt_q <= CNT_W'(1) &&
            req_q.cmd == DPM_CMD_FLAG) begin
            grant_d = (rdata_q[0] == 1'b0);
        end
    end

    // sequencer registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            req_q   <= '0;
            pins_q  <= PINS_IDLE;
            cnt_q   <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            oe_q    <= 1'b0;
            done_q  <= 1'b0;
            grant_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_q   <= req_d;
            pins_q  <= pins_d;
            cnt_q   <= cnt_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            oe_q    <= oe_d;
            done_q  <= done_d;
            grant_q <= grant_d;
        end
    end

    // ready is registered so the port stays flop-driven
    logic ready_q;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_q <= 1'b1;
        end else begin
            ready_q <= (state_d == ST_IDLE) && !(state_q == ST_IDLE &&
                                                 req_valid_in);
        end
    end

    // outputs straight from flops
    assign req_ready_out = ready_q;
    assign done_out      = done_q;
    assign rdata_out     = rdata_q;
    assign granted_out   = grant_q;
    assign pins_out      = pins_q;
    assign data_out      = wdata_q;
    assign data_oe_out   = oe_q;
endmodule
`default_nettype wire

// ---- dpm_host_asserts.sv ----
// checker: strobe order and timing properties of the port controller
`timescale 1ns/1ps
`default_nettype none
module dpm_host_asserts
    import dpm_pkg::*;
(
    input wire logic              ref_clk_in,    // clock
    input wire logic              rst_in,        // reset
    input wire dpm_req_t          req_in,        // request
    input wire logic              req_valid_in,  // offered
    input wire logic              req_ready_out, // idle
    input wire logic              done_out,      // completion
    input wire logic [DATA_W-1:0] rdata_out,     // read data
    input wire logic              granted_out,   // grant
    input wire dpm_pins_t         pins_out,      // strobes
    input wire logic [DATA_W-1:0] data_out,      // host data
    input wire logic              data_oe_out,   // host drives
    input wire logic [DATA_W-1:0] data_in        // pin level
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic tk;
    // request taken on this edge
    assign tk = req_valid_in && req_ready_out;

    a_sel_exclusive:
        assert property (pins_out.sel_n || pins_out.flag_select_n)
        else $error("both selects low");
    a_addr_rw_high:
        assert property ($changed(pins_out.addr) |->
            pins_out.rw && $past(pins_out.rw)) else $error("addr moved");
    a_no_bus_fight:
        assert property (data_oe_out |-> pins_out.oe_n &&
            $past(pins_out.oe_n)) else $error("drive with oe low");
    a_write_data_hold:
        assert property (!pins_out.rw && !$past(pins_out.rw) |->
            data_oe_out && $stable(data_out)) else $error("data moved");
    a_addr_before_sel:
        assert property ($fell(pins_out.sel_n) |->
            $stable(pins_out.addr)) else $error("addr late");
    a_write_length:
        assert property (tk && req_in.cmd == DPM_CMD_WRITE |-> ##8 done_out)
        else $error("write done late");
    a_flag_pulse:
        assert property ($fell(pins_out.flag_select_n) |->
            (!pins_out.flag_select_n) [*2]) else $error("flag pulse short");
    a_read_strobe:
        assert property (!pins_out.oe_n |-> pins_out.rw && !data_oe_out)
        else $error("bad read strobes");
    a_take_sel_high:
        assert property (tk && req_in.cmd == DPM_CMD_TAKE |->
            pins_out.sel_n [*8]) else $error("select low in take");
    c_write: cover property (tk && req_in.cmd == DPM_CMD_WRITE);
    c_grant: cover property ($rose(granted_out));
    c_flag_rd: cover property (!pins_out.oe_n && !pins_out.flag_select_n);
endmodule
bind dpm_host dpm_host_asserts dpm_host_asserts_i (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .req_in(req_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .done_out(done_out),
    .rdata_out(rdata_out), .granted_out(granted_out), .pins_out(pins_out),
    .data_out(data_out), .data_oe_out(data_oe_out), .data_in(data_in));
`default_nettype wire

// ---- dpm_dev_model.sv ----
// behavioural model of one memory port with its flags
`timescale 1ns/1ps
`default_nettype none
module dpm_dev_model
    import dpm_pkg::*;
(
    input  wire logic              clk_in,   // paces float pattern
    input  wire dpm_pins_t         pins_in,  // host strobes
    input  wire logic [DATA_W-1:0] hdata_in, // host data
    input  wire logic              hoe_in,   // host drives
    input  wire logic              other_in, // far port holds flags
    output logic [DATA_W-1:0]      bus_out   // resolved pin level
);
    dpm_pins_t         p;
    logic [DATA_W-1:0] mem [0:255]; // low address byte only, aliases
    logic [7:0]        mine = 8'h00; // all flags released
    logic [DATA_W-1:0] flt = 8'hA5;
    logic              rd_arr, rd_flg, wr_arr, wr_flg;
    // decode; reads need rw high so writes float
    assign p = pins_in;
    assign rd_arr = !p.sel_n && p.rw && !p.oe_n && p.flag_select_n;
    assign rd_flg = p.sel_n && p.rw && !p.oe_n &&
                    !p.flag_select_n;
    assign wr_arr = !p.sel_n && !p.rw && p.flag_select_n;
    assign wr_flg = !p.flag_select_n && !p.rw;
    // store at end of write; same cells as far port
    always @(negedge wr_arr) mem[p.addr[7:0]] = bus_out;
    // claim unless far port holds it; one owner
    always @(negedge wr_flg) begin
        if (bus_out[0]) mine[p.addr[2:0]] = 1'b0;
        else if (!other_in) mine[p.addr[2:0]] = 1'b1;
    end
    // released pins never keep the old value, so change every cycle
    always @(posedge clk_in) flt <= flt + 8'h3B;
    // pin level; flag value only on explicit strobe
    always @* begin
        if (hoe_in && (rd_arr || rd_flg)) bus_out = 'x;
        else if (hoe_in) bus_out = hdata_in;
        else if (rd_arr) bus_out = mem[p.addr[7:0]];
        else if (rd_flg) bus_out = mine[p.addr[2:0]] ? FLAG_TAKE : FLAG_FREE;
        else bus_out = flt;
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench: port controller against the memory model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
    import dpm_pkg::*;
    typedef struct packed {dpm_cmd_t cmd; logic [DATA_W-1:0] val;} dpm_exp_t;
    logic ref_clk_in, rst_in, req_valid_in, req_ready_out, done_out;
    logic granted_out, data_oe_out, other_hold;
    logic [DATA_W-1:0] rdata_out, data_out, data_in;
    dpm_req_t          req_in;
    dpm_pins_t         pins_out;
    dpm_exp_t          exp_q[$];
    dpm_exp_t          x;
    logic [ADDR_W-1:0] wadr [8];
    logic [DATA_W-1:0] wdat [8];
    int                err_count, checks;
    dpm_host dpm_host_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .req_in(req_in), .req_valid_in(req_valid_in),
        .req_ready_out(req_ready_out), .done_out(done_out),
        .rdata_out(rdata_out), .granted_out(granted_out),
        .pins_out(pins_out), .data_out(data_out),
        .data_oe_out(data_oe_out), .data_in(data_in));
    dpm_dev_model dpm_dev_model_i (.clk_in(ref_clk_in), .pins_in(pins_out),
        .hdata_in(data_out), .hoe_in(data_oe_out), .other_in(other_hold),
        .bus_out(data_in));
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic finish_test();
        if (err_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // offer one command once idle, note what it should return
    task automatic do_req(dpm_cmd_t c, logic [ADDR_W-1:0] a,
                          logic [DATA_W-1:0] d, logic [DATA_W-1:0] e);
        int n;
        n = 0;
        @(negedge ref_clk_in);
        while (req_ready_out !== 1'b1 && n < 100) begin
            @(negedge ref_clk_in);
            n++;
        end
        `CHK("ready", 1'b1, req_ready_out)
        req_in = '{cmd: c, addr: a, data: d};
        req_valid_in = 1'b1;
        exp_q.push_back('{c, e});
        @(negedge ref_clk_in);
        req_valid_in = 1'b0;
    endtask
    // results settle by the falling edge after done
    always @(negedge ref_clk_in) if (done_out === 1'b1) begin
        if (exp_q.size() == 0)
            `CHK("done", 1'b0, 1'b1)
        else begin
            x = exp_q.pop_front();
            if (x.cmd == DPM_CMD_TAKE)
                `CHK("grant", x.val[0], granted_out)
            else if (x.cmd != DPM_CMD_WRITE && x.cmd != DPM_CMD_FREE)
                `CHK("rdata", x.val, rdata_out)
        end
    end
    // hang guard, well beyond the two hundred or so cycles needed
    initial begin
        #50000;
        err_count++;
        finish_test();
    end
    initial begin
        void'($urandom(25));
        err_count = 0;
        checks = 0;
        rst_in = 1'b1;
        req_valid_in = 1'b0;
        req_in = '0;
        other_hold = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in) rst_in = 1'b0;
        `CHK("idle pins", PINS_IDLE, pins_out)
        `CHK("idle drive", 1'b0, data_oe_out)
        do_req(DPM_CMD_FLAG, 17'h00003, 8'h00, FLAG_FREE);
        // back-to-back writes, then reads in reverse order
        for (int i = 0; i < 8; i++) begin
            wadr[i] = {9'($urandom), 8'(i * 37)};
            wdat[i] = (i == 7) ? 8'hFF : 8'($urandom);
            do_req(DPM_CMD_WRITE, wadr[i], wdat[i], 8'h00);
        end
        for (int i = 7; i >= 0; i--)
            do_req(DPM_CMD_READ, wadr[i], 8'h00, wdat[i]);
        // claim, confirm, release, confirm, then lose to far port
        do_req(DPM_CMD_TAKE, 17'h00005, 8'h00, 8'h01);
        do_req(DPM_CMD_FLAG, 17'h00005, 8'h00, FLAG_TAKE);
        do_req(DPM_CMD_FREE, 17'h00005, 8'h00, 8'h00);
        do_req(DPM_CMD_FLAG, 17'h00005, 8'h00, FLAG_FREE);
        other_hold = 1'b1;
        do_req(DPM_CMD_TAKE, 17'h00006, 8'h00, 8'h00);
        for (int n = 0; n < 100 && exp_q.size() > 0; n++)
            @(negedge ref_clk_in);
        `CHK("pending", 0, exp_q.size())
        finish_test();
    end
endmodule
`default_nettype wire
